// >>> common/file_ops_pkg.sv
// Notes on behaviour
// - Complement-file writes the inverted file value to the destination and updates only N and Z; opcode top bits 0001 11da.
// - The destination bit sends the result to the accumulator when 0 and back to the file register when 1.
// - Access bit 0 selects the access bank and ignores the bank select register; 1 uses the bank select register.
// - Compare-skip-equal drops the fetched next instruction when the file value equals the accumulator; opcode 0110 001a.
// - Compare-skip-greater skips when the file value is above the accumulator, flags untouched; opcode 0110 010a.
// - Compare-skip-less skips when the file value is below the accumulator; opcode 0110 000a.
// - Compares use unsigned file minus accumulator and change neither operand nor any flag.
// - A met skip condition adds one idle instruction cycle, or two when the two-word bit is set.
// - Decimal adjust adds 6 to each accumulator nibble that is above nine or whose carry is set, and updates carry.
// - Decrement-skip-zero stores file minus one per the destination bit and skips on a zero result, flags untouched.
// - A single-cycle file operation decodes in phase one, reads in two, computes in three and writes in four.
package file_ops_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0]  REG_INSTR     = 8'h00;
  localparam logic [7:0]  REG_ACC       = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam logic [7:0]  REG_BANK      = 8'h0c;
  localparam logic [7:0]  REG_FILE_ADDR = 8'h10;
  localparam logic [7:0]  REG_FILE_DATA = 8'h14;
  localparam logic [7:0]  REG_STATE     = 8'h18;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_DC       = 1;
  localparam int          FLAG_Z        = 2;
  localparam int          FLAG_OV       = 3;
  localparam int          FLAG_N        = 4;
  localparam int          DEST_BIT      = 9;
  localparam int          ACCESS_BIT    = 8;
  localparam int          TWO_WORD_BIT  = 16;
  localparam logic [7:0]  RST_ACC       = 8'h00;
  localparam logic [4:0]  RST_STATUS    = 5'h00;
  localparam logic [3:0]  RST_BANK      = 4'h0;
  localparam logic [11:0] RST_FILE_ADDR = 12'h000;
  localparam logic [15:0] RST_INSTR     = 16'h0000;

  // ****************************************
  // Opcode patterns and constants
  // ****************************************
  localparam logic [5:0]  PAT_COMPLEMENT     = 6'h07;
  localparam logic [5:0]  PAT_DECREMENT      = 6'h01;
  localparam logic [5:0]  PAT_DEC_SKIP       = 6'h0b;
  localparam logic [6:0]  PAT_CMP_EQ         = 7'h31;
  localparam logic [6:0]  PAT_CMP_GT         = 7'h32;
  localparam logic [6:0]  PAT_CMP_LT         = 7'h30;
  localparam logic [15:0] PAT_DECIMAL_ADJUST = 16'h0070;
  localparam logic [7:0]  ACCESS_SPLIT       = 8'h80;
  localparam logic [3:0]  ACCESS_HIGH_BANK   = 4'hf;
  localparam logic [3:0]  ACCESS_LOW_BANK    = 4'h0;
  localparam logic [3:0]  BCD_DIGIT_MAX      = 4'h9;
  localparam logic [8:0]  BCD_LOW_FIX        = 9'h006;
  localparam logic [8:0]  BCD_HIGH_FIX       = 9'h060;
  localparam logic [1:0]  PHASE_LAST         = 2'h3;
  localparam logic [1:0]  IDLE_ONE           = 2'h1;
  localparam logic [1:0]  IDLE_TWO           = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE, OP_COMPLEMENT, OP_DECREMENT, OP_DEC_SKIP,
    OP_CMP_EQ, OP_CMP_GT, OP_CMP_LT, OP_DECIMAL_ADJUST
  } op_t;

  typedef enum logic [2:0] {EX_IDLE, EX_Q1, EX_Q2, EX_Q3, EX_Q4, EX_SKIP} exec_t;

  typedef struct packed {
    logic [7:0] result;
    logic [4:0] status;
    logic       to_file;
    logic       to_acc;
    logic       skip;
  } alu_out_t;

  typedef struct packed {
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        dphase;
    logic        dwrite;
    logic [7:0]  daddr;
    logic [15:0] instr;
    logic        two_word;
    exec_t       ex;
    op_t         op;
    logic [1:0]  idle_left;
    logic [1:0]  phase;
    logic [7:0]  acc;
    logic [4:0]  status;
    logic [3:0]  bank_sel;
    logic [11:0] file_addr;
    logic [11:0] eff_addr;
    alu_out_t    res;
    logic        skip_seen;
  } core_state_t;

  function automatic op_t decode_op(input logic [15:0] ins);
    if (ins == PAT_DECIMAL_ADJUST) return OP_DECIMAL_ADJUST;
    if (ins[15:10] == PAT_COMPLEMENT) return OP_COMPLEMENT;
    if (ins[15:10] == PAT_DECREMENT) return OP_DECREMENT;
    if (ins[15:10] == PAT_DEC_SKIP) return OP_DEC_SKIP;
    if (ins[15:9] == PAT_CMP_EQ) return OP_CMP_EQ;
    if (ins[15:9] == PAT_CMP_GT) return OP_CMP_GT;
    if (ins[15:9] == PAT_CMP_LT) return OP_CMP_LT;
    return OP_NONE;
  endfunction

  function automatic logic [11:0] access_addr(input logic [15:0] ins,
                                              input logic [3:0] bank);
    if (ins[ACCESS_BIT]) return {bank, ins[7:0]};
    if (ins[7:0] >= ACCESS_SPLIT) return {ACCESS_HIGH_BANK, ins[7:0]};
    return {ACCESS_LOW_BANK, ins[7:0]};
  endfunction

endpackage

// >>> hw/file_compare_decrement_ops.sv
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module file_compare_decrement_ops #(
  parameter int BANK_W = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  import file_ops_pkg::*;

  localparam int AW = BANK_W + 8;

  if (BANK_W < 1 || BANK_W > 4) begin : g_bad
    $error("file_compare_decrement_ops: BANK_W must be 1 to 4");
  end

  core_state_t    st;
  core_state_t    next_st;
  logic           bus_go;
  logic           exec_idle;
  logic           mem_we;
  logic [AW-1:0]  mem_waddr;
  logic [7:0]     mem_wdata;
  logic [AW-1:0]  mem_raddr;
  logic [7:0]     mem_rdata;
  alu_out_t       alu_res;
  logic [31:0]    read_word;

  // ****************************************
  // File memory and datapath
  // ****************************************
  file_ram #(
    .DATA_W (8),
    .ADDR_W (AW)
  ) u_ram (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  file_ops_alu u_alu (
    .op     (st.op),
    .dest   (st.instr[DEST_BIT]),
    .fval   (mem_rdata),
    .acc    (st.acc),
    .status (st.status),
    .res    (alu_res)
  );

  assign hreadyout = st.hreadyout;
  assign hrdata    = st.hrdata;
  assign hresp     = st.hresp;

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb
  begin
    read_word = 32'h0000_0000;
    case (st.daddr)
      REG_INSTR:     read_word = {15'h0000, st.two_word, st.instr};
      REG_ACC:       read_word = {24'h000000, st.acc};
      REG_STATUS:    read_word = {27'h0000000, st.status};
      REG_BANK:      read_word = {28'h0000000, st.bank_sel};
      REG_FILE_ADDR: read_word = {20'h00000, st.file_addr};
      REG_FILE_DATA: read_word = {24'h000000, mem_rdata};
      REG_STATE:     read_word = {28'h0000000, st.skip_seen, st.idle_left,
                                  (st.ex != EX_IDLE)};
      default:       read_word = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    bus_go = hsel && htrans[1] && hready;
    exec_idle = (st.ex == EX_IDLE);
    mem_we = 1'b0;
    mem_waddr = st.file_addr[AW-1:0];
    mem_wdata = hwdata[7:0];
    mem_raddr = st.file_addr[AW-1:0];

    // Bus slave: one wait state, held while an instruction runs
    if (bus_go)
    begin
      next_st.dphase = 1'b1;
      next_st.dwrite = hwrite;
      next_st.daddr = haddr[7:0];
      next_st.hreadyout = 1'b0;
    end
    else if (st.dphase && exec_idle)
    begin
      next_st.dphase = 1'b0;
      next_st.hreadyout = 1'b1;
      if (st.dwrite)
      begin
        case (st.daddr)
          REG_INSTR:
          begin
            next_st.instr = hwdata[15:0];
            next_st.two_word = hwdata[TWO_WORD_BIT];
            next_st.ex = EX_Q1;
          end
          REG_ACC:       next_st.acc = hwdata[7:0];
          REG_STATUS:    next_st.status = hwdata[4:0];
          REG_BANK:      next_st.bank_sel = hwdata[3:0];
          REG_FILE_ADDR: next_st.file_addr = hwdata[11:0];
          REG_FILE_DATA: mem_we = 1'b1;
          default:       next_st.hresp = 1'b0;
        endcase
      end
      else
      begin
        next_st.hrdata = read_word;
      end
    end

    // Instruction sequencer, four phases per cycle
    case (st.ex)
      EX_IDLE: next_st.phase = 2'h0;
      EX_Q1:
      begin
        next_st.op = decode_op(st.instr);
        next_st.eff_addr = access_addr(st.instr, st.bank_sel);
        next_st.ex = EX_Q2;
      end
      EX_Q2:
      begin
        mem_raddr = st.eff_addr[AW-1:0];
        next_st.ex = EX_Q3;
      end
      EX_Q3:
      begin
        next_st.res = alu_res;
        next_st.ex = EX_Q4;
      end
      EX_Q4:
      begin
        if (st.res.to_file)
        begin
          mem_we = 1'b1;
          mem_waddr = st.eff_addr[AW-1:0];
          mem_wdata = st.res.result;
        end
        if (st.res.to_acc)
        begin
          next_st.acc = st.res.result;
        end
        next_st.status = st.res.status;
        next_st.skip_seen = st.res.skip;
        next_st.phase = 2'h0;
        if (st.res.skip)
        begin
          next_st.idle_left = st.two_word ? IDLE_TWO : IDLE_ONE;
          next_st.ex = EX_SKIP;
        end
        else
        begin
          next_st.ex = EX_IDLE;
        end
      end
      EX_SKIP:
      begin
        next_st.phase = st.phase + 2'h1;
        if (st.phase == PHASE_LAST)
        begin
          next_st.idle_left = st.idle_left - 2'h1;
          if (st.idle_left == IDLE_ONE)
          begin
            next_st.ex = EX_IDLE;
          end
        end
      end
      default: next_st.ex = EX_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.hreadyout <= 1'b1;
      st.instr <= RST_INSTR;
      st.ex <= EX_IDLE;
      st.op <= OP_NONE;
      st.acc <= RST_ACC;
      st.status <= RST_STATUS;
      st.bank_sel <= RST_BANK;
      st.file_addr <= RST_FILE_ADDR;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  AST_COMPLEMENT:
    assert property ((st.ex == EX_Q3 && st.op == OP_COMPLEMENT && st.instr[DEST_BIT])
      |=> (mem_we && mem_wdata == ~$past(mem_rdata)))
    else $error("complement result not written to file");

  AST_DEST_ACC:
    assert property ((st.ex == EX_Q4 && st.res.to_acc)
      |=> (st.acc == $past(st.res.result)))
    else $error("result not routed to accumulator");

  AST_ACCESS_BANK:
    assert property ((st.ex == EX_Q2 && !st.instr[ACCESS_BIT] && !st.instr[7])
      |-> (mem_raddr == {{(AW-8){1'b0}}, st.instr[7:0]}))
    else $error("access bank not selected");

  AST_SKIP_EQ:
    assert property ((st.ex == EX_Q3 && st.op == OP_CMP_EQ && mem_rdata == st.acc)
      |=> st.res.skip)
    else $error("equal compare did not skip");

  AST_SKIP_GT:
    assert property ((st.ex == EX_Q3 && st.op == OP_CMP_GT)
      |=> (st.res.skip == ($past(mem_rdata) > $past(st.acc)))
      ##1 (st.status == $past(st.status, 2)))
    else $error("greater compare wrong or flags changed");

  AST_SKIP_LT:
    assert property ((st.ex == EX_Q3 && st.op == OP_CMP_LT)
      |=> (st.res.skip == ($past(mem_rdata) < $past(st.acc))))
    else $error("less compare wrong");

  AST_CMP_KEEP:
    assert property ((st.ex == EX_Q4 && (st.op == OP_CMP_EQ || st.op == OP_CMP_LT))
      |=> (!$past(mem_we) && $stable(st.acc) && $stable(st.status)))
    else $error("compare disturbed operands or flags");

  AST_SKIP_ONE:
    assert property ((st.ex == EX_Q4 && st.res.skip && !st.two_word)
      |=> (st.ex == EX_SKIP)[*4] ##1 (st.ex == EX_IDLE))
    else $error("single idle slot length wrong");

  AST_SKIP_TWO:
    assert property ((st.ex == EX_Q4 && st.res.skip && st.two_word)
      |=> (st.ex == EX_SKIP)[*8] ##1 (st.ex == EX_IDLE))
    else $error("double idle slot length wrong");

  AST_DAW:
    assert property ((st.ex == EX_Q3 && st.op == OP_DECIMAL_ADJUST && st.acc == 8'hce
      && st.status[FLAG_DC:FLAG_C] == 2'b00)
      |=> ##1 (st.acc == 8'h34 && st.status[FLAG_C]))
    else $error("decimal adjust wrong");

  AST_DEC_SKIP:
    assert property ((st.ex == EX_Q3 && st.op == OP_DEC_SKIP && mem_rdata == 8'h01)
      |=> (st.res.skip && st.res.result == 8'h00) ##1 (st.ex == EX_SKIP))
    else $error("decrement to zero did not skip");

  AST_PHASES:
    assert property ((st.ex == EX_Q1)
      |=> (st.ex == EX_Q2) ##1 (st.ex == EX_Q3) ##1 (st.ex == EX_Q4))
    else $error("phase order broken");

  AST_DEC_FLAGS:
    assert property ((st.ex == EX_Q3 && st.op == OP_DECREMENT && mem_rdata == 8'h80)
      |=> ##1 (st.status[FLAG_OV] && !st.status[FLAG_N] && st.status[FLAG_C]))
    else $error("decrement flags wrong");

  AST_COMPLEMENT_FLAGS:
    assert property ((st.ex == EX_Q3 && st.op == OP_COMPLEMENT)
      |=> ##1 (st.status[FLAG_DC:FLAG_C] == $past(st.status[FLAG_DC:FLAG_C], 2)
      && st.status[FLAG_OV] == $past(st.status[FLAG_OV], 2)
      && st.status[FLAG_Z] == ($past(mem_rdata, 2) == 8'hff)
      && st.status[FLAG_N] == !$past(mem_rdata[7], 2)))
    else $error("complement flags wrong");

  AST_DEST_FILE:
    assert property ((st.ex == EX_Q4 && st.res.to_file)
      |-> (mem_we && mem_waddr == st.eff_addr[AW-1:0] && mem_wdata == st.res.result))
    else $error("result not routed to file register");

  AST_FILE_KEEPS_ACC:
    assert property ((st.ex == EX_Q4 && st.res.to_file)
      |=> (st.acc == $past(st.acc)))
    else $error("file destination changed the accumulator");

  AST_ACCESS_HIGH:
    assert property ((st.ex == EX_Q2 && !st.instr[ACCESS_BIT] && st.instr[7])
      |-> (mem_raddr == {{(AW-8){1'b1}}, st.instr[7:0]}))
    else $error("upper access bank not selected");

  AST_BANK_SELECT:
    assert property ((st.ex == EX_Q2 && st.instr[ACCESS_BIT])
      |-> (mem_raddr == {st.bank_sel[BANK_W-1:0], st.instr[7:0]}))
    else $error("bank select register not applied");

  AST_GT_KEEP:
    assert property ((st.ex == EX_Q4 && st.op == OP_CMP_GT)
      |=> (!$past(mem_we) && $stable(st.acc) && $stable(st.status)))
    else $error("greater compare disturbed operands or flags");

  AST_CMP_NO_WRITE:
    assert property ((st.ex == EX_Q4
      && (st.op == OP_CMP_EQ || st.op == OP_CMP_GT || st.op == OP_CMP_LT))
      |-> (!mem_we && !st.res.to_acc))
    else $error("compare wrote a result");

  AST_NO_SKIP_END:
    assert property ((st.ex == EX_Q4 && !st.res.skip)
      |=> (st.ex == EX_IDLE))
    else $error("idle slot added without a skip");

  AST_DAW_FLAGS:
    assert property ((st.ex == EX_Q3 && st.op == OP_DECIMAL_ADJUST)
      |=> ##1 (st.status[FLAG_N:FLAG_DC] == $past(st.status[FLAG_N:FLAG_DC], 2)))
    else $error("decimal adjust changed flags other than carry");

  AST_DAW_LOW:
    assert property ((st.ex == EX_Q3 && st.op == OP_DECIMAL_ADJUST && st.acc == 8'h12
      && st.status[FLAG_DC] && !st.status[FLAG_C])
      |=> ##1 (st.acc == 8'h18 && !st.status[FLAG_C]))
    else $error("decimal adjust low digit wrong");

  AST_DEC_SKIP_KEEP:
    assert property ((st.ex == EX_Q3 && st.op == OP_DEC_SKIP)
      |=> ##1 (st.status == $past(st.status, 2)))
    else $error("decrement skip changed flags");

  AST_DEC_SKIP_STORE:
    assert property ((st.ex == EX_Q3 && st.op == OP_DEC_SKIP && st.instr[DEST_BIT])
      |=> (mem_we && mem_wdata == $past(mem_rdata) - 8'h01))
    else $error("decrement skip result not stored");

  AST_DEC_TO_ACC:
    assert property ((st.ex == EX_Q3 && st.op == OP_DECREMENT && !st.instr[DEST_BIT])
      |=> ##1 (st.acc == $past(mem_rdata, 2) - 8'h01))
    else $error("decrement result not in accumulator");

endmodule // file_compare_decrement_ops

// >>> hw/file_ops_alu.sv
`timescale 1ns/1ps
module file_ops_alu (
  input  wire file_ops_pkg::op_t  op,
  input  wire logic               dest,
  input  wire logic [7:0]         fval,
  input  wire logic [7:0]         acc,
  input  wire logic [4:0]         status,
  output file_ops_pkg::alu_out_t  res
);
  import file_ops_pkg::*;

  logic [7:0] dec;
  logic [8:0] diff;
  logic [8:0] bcd;

  // ****************************************
  // Combinational datapath
  // ****************************************
  always_comb
  begin
    dec = fval - 8'h01;
    diff = {1'b0, fval} - {1'b0, acc};
    bcd = {1'b0, acc};
    res = '0;
    res.status = status;
    case (op)
      OP_COMPLEMENT:
      begin
        res.result = ~fval;
        res.status[FLAG_N] = ~fval[7];
        res.status[FLAG_Z] = (fval == 8'hff);
        res.to_file = dest;
        res.to_acc = !dest;
      end
      OP_DECREMENT:
      begin
        res.result = dec;
        res.status[FLAG_C] = (fval != 8'h00);
        res.status[FLAG_DC] = (fval[3:0] != 4'h0);
        res.status[FLAG_OV] = (fval == 8'h80);
        res.status[FLAG_N] = dec[7];
        res.status[FLAG_Z] = (dec == 8'h00);
        res.to_file = dest;
        res.to_acc = !dest;
      end
      OP_DEC_SKIP:
      begin
        res.result = dec;
        res.to_file = dest;
        res.to_acc = !dest;
        res.skip = (dec == 8'h00);
      end
      OP_CMP_EQ: res.skip = (diff == 9'h000);
      OP_CMP_GT: res.skip = !diff[8] && (diff != 9'h000);
      OP_CMP_LT: res.skip = diff[8];
      OP_DECIMAL_ADJUST:
      begin
        if (acc[3:0] > BCD_DIGIT_MAX || status[FLAG_DC])
        begin
          bcd = bcd + BCD_LOW_FIX;
        end
        if (bcd[7:4] > BCD_DIGIT_MAX || status[FLAG_C])
        begin
          bcd = bcd + BCD_HIGH_FIX;
        end
        res.result = bcd[7:0];
        res.status[FLAG_C] = bcd[8] | status[FLAG_C];
        res.to_acc = 1'b1;
      end
      default: res = '0;
    endcase
    if (op == OP_NONE)
    begin
      res.status = status;
    end
  end
endmodule // file_ops_alu

// >>> hw/file_ram.sv
`timescale 1ns/1ps
module file_ram #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  if (DATA_W < 1 || ADDR_W < 1) begin : g_bad
    $error("file_ram: widths must be positive");
  end

  // ****************************************
  // Write-through storage
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
  end
endmodule // file_ram

// >>> sim/tb_file_compare_decrement_ops.sv
`timescale 1ns/1ps
module tb_file_compare_decrement_ops;
  import file_ops_pkg::*;

  // ****************************************
  // Signals and design
  // ****************************************
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [31:0] rd_last;
  logic [31:0] st;
  logic        sk;
  int          err_total = 0;
  int          cmp_count = 0;
  int          edges = 0;
  int          dur;
  int          d_base;
  int          d_skip;
  logic [7:0]  dec_in[3]  = '{8'h01, 8'h80, 8'h00};
  logic [7:0]  dec_out[3] = '{8'h00, 8'h7f, 8'hff};
  logic [4:0]  dec_st[3]  = '{5'h07, 5'h09, 5'h10};
  logic [6:0]  cmp_pat[3] = '{PAT_CMP_EQ, PAT_CMP_GT, PAT_CMP_LT};
  logic [7:0]  cmp_f[3]   = '{8'h40, 8'h80, 8'h7f};
  logic [7:0]  cmp_w[3]   = '{8'h40, 8'h7f, 8'h80};
  logic [7:0]  da_in[4]   = '{8'ha5, 8'hce, 8'h12, 8'h99};
  logic [4:0]  da_sin[4]  = '{5'h00, 5'h00, 5'h02, 5'h01};
  logic [7:0]  da_out[4]  = '{8'h05, 8'h34, 8'h18, 8'hf9};
  logic [4:0]  da_st[4]   = '{5'h01, 5'h01, 5'h02, 5'h01};

  assign hready = hreadyout;

  file_compare_decrement_ops file_compare_decrement_ops_i (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      edges++;
    end
    while (hreadyout !== 1'b1 && n < 200);
    rd_last = hrdata;
    if (hreadyout !== 1'b1)
    begin
      err_total++;
      $display("Error bus wait expected ready seen stalled");
      tally_and_finish();
    end
    @(posedge clk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd_last);
  endtask

  task automatic setf(input logic [11:0] fa, input logic [7:0] v);
    bus(1'b1, REG_FILE_ADDR, {20'h0, fa});
    bus(1'b1, REG_FILE_DATA, {24'h0, v});
  endtask

  task automatic expect_file(input logic [11:0] fa, input logic [7:0] e);
    bus(1'b1, REG_FILE_ADDR, {20'h0, fa});
    expect_reg("file", REG_FILE_DATA, {24'h0, e});
  endtask

  task automatic run(input logic [31:0] ins);
    int t0;
    bus(1'b1, REG_INSTR, ins);
    t0 = edges;
    bus(1'b0, REG_STATE, 32'h0);
    dur = edges - t0;
    st = rd_last;
  endtask

  function automatic logic [31:0] fop(input logic [5:0] p, input logic d, input logic a,
                                      input logic [7:0] f);
    return {16'h0, p, d, a, f};
  endfunction

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    expect_reg("acc", REG_ACC, 32'h0);
    expect_reg("status", REG_STATUS, 32'h0);
    expect_reg("bank", REG_BANK, 32'h0);
    expect_reg("file_addr", REG_FILE_ADDR, 32'h0);
    bus(1'b1, 8'h1c, 32'hffffffff);
    expect_reg("unmapped", 8'h1c, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("Test reset_map done");

    bus(1'b1, REG_BANK, 32'h2);
    setf(12'h213, 8'h13);
    bus(1'b1, REG_STATUS, 32'h01);
    bus(1'b1, REG_ACC, 32'h55);
    run(fop(PAT_COMPLEMENT, 1'b1, 1'b1, 8'h13));
    expect_file(12'h213, 8'hec);
    expect_reg("acc", REG_ACC, 32'h55);
    expect_reg("status", REG_STATUS, 32'h11);
    setf(12'hf90, 8'hff);
    run(fop(PAT_COMPLEMENT, 1'b0, 1'b0, 8'h90));
    expect_reg("acc", REG_ACC, 32'h00);
    expect_reg("status", REG_STATUS, 32'h05);
    expect_file(12'hf90, 8'hff);
    setf(12'h220, 8'h33);
    setf(12'h020, 8'h0f);
    run(fop(PAT_COMPLEMENT, 1'b1, 1'b0, 8'h20));
    expect_file(12'h020, 8'hf0);
    expect_file(12'h220, 8'h33);
    $display("Test complement done");

    for (int i = 0; i < 3; i++)
    begin
      setf(12'h230, dec_in[i]);
      bus(1'b1, REG_STATUS, 32'h1f);
      run(fop(PAT_DECREMENT, 1'b1, 1'b1, 8'h30));
      expect_file(12'h230, dec_out[i]);
      expect_reg("status", REG_STATUS, {27'h0, dec_st[i]});
    end
    run(fop(PAT_DECREMENT, 1'b0, 1'b1, 8'h30));
    expect_reg("acc", REG_ACC, 32'hfe);
    expect_file(12'h230, 8'hff);
    $display("Test decrement done");

    bus(1'b1, REG_STATUS, 32'h15);
    setf(12'h231, 8'h05);
    run(fop(PAT_DEC_SKIP, 1'b1, 1'b1, 8'h31));
    d_base = dur;
    chk("skipped", 32'h0, {31'h0, st[3]});
    expect_file(12'h231, 8'h04);
    setf(12'h231, 8'h01);
    run(fop(PAT_DEC_SKIP, 1'b1, 1'b1, 8'h31));
    d_skip = dur;
    chk("skipped", 32'h1, {31'h0, st[3]});
    chk("skip time", d_base + 4, d_skip);
    expect_file(12'h231, 8'h00);
    setf(12'h231, 8'h01);
    run(fop(PAT_DEC_SKIP, 1'b1, 1'b1, 8'h31) | 32'h10000);
    chk("two word time", d_skip + 4, dur);
    expect_reg("status", REG_STATUS, 32'h15);
    $display("Test decrement_skip done");

    for (int i = 0; i < 3; i++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        bus(1'b1, REG_ACC, {24'h0, cmp_w[j]});
        setf(12'h040, cmp_f[j]);
        bus(1'b1, REG_STATUS, 32'h0a);
        run({16'h0, cmp_pat[i], 1'b0, 8'h40});
        sk = (i == 0) ? (cmp_f[j] == cmp_w[j]) :
             (i == 1) ? (cmp_f[j] > cmp_w[j]) : (cmp_f[j] < cmp_w[j]);
        chk("cmp skipped", {31'h0, sk}, {31'h0, st[3]});
        chk("cmp time", d_base + (sk ? 4 : 0), dur);
        expect_reg("acc", REG_ACC, {24'h0, cmp_w[j]});
        expect_reg("status", REG_STATUS, 32'h0a);
        expect_file(12'h040, cmp_f[j]);
      end
    end
    $display("Test compare done");

    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, REG_ACC, {24'h0, da_in[i]});
      bus(1'b1, REG_STATUS, {27'h0, da_sin[i]});
      run({16'h0, PAT_DECIMAL_ADJUST});
      expect_reg("acc", REG_ACC, {24'h0, da_out[i]});
      expect_reg("status", REG_STATUS, {27'h0, da_st[i]});
    end
    $display("Test decimal_adjust done");
    run(32'h0001_ffff);
    chk("none time", d_base, dur);
    expect_reg("instr", REG_INSTR, 32'h0001ffff);
    expect_reg("acc", REG_ACC, {24'h0, da_out[3]});
    expect_reg("status", REG_STATUS, {27'h0, da_st[3]});
    $display("Test unknown_op done");
    tally_and_finish();
  end

endmodule // tb_file_compare_decrement_ops
